// ---- hdl/chg_config_regs.sv ----
`timescale 1ns/1ps
module chg_config_regs
    import chg_pkg::*;
#(
    parameter int MS_CYCLES_P = MS_CYCLES
)(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst,
    // Host bus pins
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_n,
    // Charger status in
    input  wire logic [1:0] charge_state,
    input  wire logic [2:0] fault_code,
    input  wire logic       vbat_below_short,
    input  wire logic       safety_limit_reset_pin_n,
    input  wire logic [3:0] fast_charge_req_code,
    // Charger controls out
    output logic            safety_timer_restart,
    output logic            stat_enable,
    output logic [1:0]      input_current_limit_sel,
    output logic [1:0]      weak_battery_threshold,
    output logic            termination_enable,
    output logic            charger_disable,
    output logic            high_impedance_select,
    output logic [5:0]      battery_voltage_code,
    output logic [3:0]      fast_charge_code,
    // Safety limits out
    output logic [3:0]      max_charge_current_code,
    output logic [3:0]      max_regulation_voltage_code,
    output logic            safety_limit_locked,
    // Indicator out
    output logic [1:0]      indicator_current_sel,
    output logic            indicator_on
);

    logic       wr_stb, map_ac;
    logic [7:0] wr_data, reg_ptr, rd_data;

    logic       stat_en_r;
    logic [7:0] control_r, voltage_r, safety_r, indicator_r;
    logic       lock_r, restart_r;

    logic       wr_status, wr_control, wr_voltage, wr_safety, wr_indicator;
    logic       limit_reset;
    logic [5:0] vreg_limit;

    logic [15:0] prescale_r;
    logic        ms_tick;
    logic [11:0] ms_cnt_r, on_ms, off_ms;
    logic        phase_on_r, ind_enable;
    logic [1:0]  behav_cur, on_sel, off_sel;

    chg_i2c_target chg_i2c_target_i (
        .mclk     (mclk),
        .rst      (rst),
        .scl_i    (scl_i),
        .sda_i    (sda_i),
        .sda_o    (sda_o),
        .sda_oe_n (sda_oe_n),
        .wr_stb   (wr_stb),
        .wr_data  (wr_data),
        .map_ac   (map_ac),
        .reg_ptr  (reg_ptr),
        .rd_data  (rd_data)
    );

    // Write decode per map
    assign wr_status    = wr_stb & map_ac & (reg_ptr == OFS_STATUS_CTRL);
    assign wr_control   = wr_stb & map_ac & (reg_ptr == OFS_CONTROL);
    assign wr_voltage   = wr_stb & map_ac & (reg_ptr == OFS_VOLTAGE);
    assign wr_safety    = wr_stb & ~map_ac & (reg_ptr == OFS_SAFETY);
    assign wr_indicator = wr_stb & ~map_ac & (reg_ptr == OFS_INDICATOR);

    // Short battery or pin pulled low restores limits
    assign limit_reset = vbat_below_short | ~safety_limit_reset_pin_n;

    // Safety limit register and its lock
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            safety_r <= RST_SAFETY;
            lock_r   <= 1'b0;
        end else if (limit_reset) begin
            safety_r <= RST_SAFETY;
            lock_r   <= 1'b0;
        end else begin
            if (wr_safety && !lock_r)
                safety_r <= wr_data;
            // Any other mapped write freezes the limits, defaults included
            if (wr_status || wr_control || wr_voltage || wr_indicator)
                lock_r <= 1'b1;
        end
    end

    // AC status/control writable part
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stat_en_r <= RST_STAT_EN;
            restart_r <= 1'b0;
        end else begin
            restart_r <= wr_status & wr_data[BIT_TMR_RESTART];
            if (wr_status)
                stat_en_r <= wr_data[BIT_STAT_EN];
        end
    end

    // Control and charge voltage registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            control_r <= RST_CONTROL & MASK_CONTROL;
            voltage_r <= RST_VOLTAGE & MASK_VOLTAGE;
        end else begin
            if (wr_control)
                control_r <= wr_data & MASK_CONTROL;
            if (wr_voltage)
                voltage_r <= wr_data & MASK_VOLTAGE;
        end
    end

    // Indicator configuration
    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            indicator_r <= RST_INDICATOR;
        else if (wr_indicator)
            indicator_r <= wr_data & MASK_INDICATOR;
    end

    // Read-back mux; unmapped offsets read zero
    always_comb begin
        rd_data = 8'h00;
        if (map_ac) begin
            case (reg_ptr)
                OFS_STATUS_CTRL: rd_data = {safety_limit_reset_pin_n, stat_en_r, charge_state, 1'b0, fault_code};
                OFS_CONTROL:     rd_data = control_r;
                OFS_VOLTAGE:     rd_data = voltage_r;
                default:         rd_data = 8'h00;
            endcase
        end else begin
            case (reg_ptr)
                OFS_SAFETY:    rd_data = safety_r;
                OFS_INDICATOR: rd_data = indicator_r;
                default:       rd_data = 8'h00;
            endcase
        end
    end

    // Voltage ceiling in charge-voltage code units
    assign vreg_limit = VREG_LIMIT_BASE + {2'b00, safety_r[3:0]};

    // Registered control outputs; clamps keep stored value for read-back
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            safety_timer_restart        <= 1'b0;
            stat_enable                 <= RST_STAT_EN;
            input_current_limit_sel     <= RST_CONTROL[7:6];
            weak_battery_threshold      <= RST_CONTROL[5:4];
            termination_enable          <= RST_CONTROL[BIT_TE];
            charger_disable             <= RST_CONTROL[BIT_CE];
            high_impedance_select       <= RST_CONTROL[BIT_HZ];
            battery_voltage_code        <= RST_VOLTAGE[7:2];
            fast_charge_code            <= 4'h0;
            max_charge_current_code     <= RST_SAFETY[7:4];
            max_regulation_voltage_code <= RST_SAFETY[3:0];
            safety_limit_locked         <= 1'b0;
            indicator_current_sel       <= RST_INDICATOR[7:6];
        end else begin
            safety_timer_restart        <= restart_r;
            stat_enable                 <= stat_en_r;
            input_current_limit_sel     <= control_r[7:6];
            weak_battery_threshold      <= control_r[5:4];
            termination_enable          <= control_r[BIT_TE];
            charger_disable             <= control_r[BIT_CE];
            high_impedance_select       <= control_r[BIT_HZ];
            battery_voltage_code        <= (voltage_r[7:2] > vreg_limit) ? vreg_limit : voltage_r[7:2];
            fast_charge_code            <= (fast_charge_req_code > safety_r[7:4]) ?
                                           safety_r[7:4] : fast_charge_req_code;
            max_charge_current_code     <= safety_r[7:4];
            max_regulation_voltage_code <= safety_r[3:0];
            safety_limit_locked         <= lock_r;
            indicator_current_sel       <= indicator_r[7:6];
        end
    end

    // Millisecond prescaler for the indicator timing
    assign ms_tick = (prescale_r == 16'(MS_CYCLES_P - 1));

    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            prescale_r <= 16'h0000;
        else if (ms_tick)
            prescale_r <= 16'h0000;
        else
            prescale_r <= prescale_r + 16'h0001;
    end

    assign behav_cur = indicator_r[7:6];
    assign on_sel    = indicator_r[3:2];
    assign off_sel   = indicator_r[1:0];

    // Gated by charging unless told to show always
    assign ind_enable = (behav_cur != IND_CUR_OFF) &&
                        (indicator_r[BIT_IND_BEHAV] || charge_state == CHG_STATE_CHARGING);

    always_comb begin
        case (on_sel)
            2'h0:    on_ms = IND_ON_MS_0;
            2'h1:    on_ms = IND_ON_MS_1;
            default: on_ms = IND_ON_MS_2;
        endcase
        case (off_sel)
            2'h0:    off_ms = IND_OFF_MS_0;
            2'h1:    off_ms = IND_OFF_MS_1;
            2'h2:    off_ms = IND_OFF_MS_2;
            default: off_ms = IND_OFF_MS_3;
        endcase
    end

    // Blink phase; restarts lit whenever the indicator is gated off
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            phase_on_r <= 1'b1;
            ms_cnt_r   <= 12'h000;
        end else if (!ind_enable || on_sel == IND_ON_CONSTANT) begin
            phase_on_r <= 1'b1;
            ms_cnt_r   <= 12'h000;
        end else if (ms_tick) begin
            if (ms_cnt_r >= (phase_on_r ? on_ms : off_ms) - 12'h001) begin
                phase_on_r <= ~phase_on_r;
                ms_cnt_r   <= 12'h000;
            end else begin
                ms_cnt_r <= ms_cnt_r + 12'h001;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            indicator_on <= 1'b0;
        else
            indicator_on <= ind_enable & phase_on_r;
    end

endmodule // chg_config_regs

// ---- hdl/chg_i2c_target.sv ----
`timescale 1ns/1ps
module chg_i2c_target
    import chg_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst,
    // Bus pins
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_n,
    // Register side
    output logic            wr_stb,
    output logic [7:0]      wr_data,
    output logic            map_ac,
    output logic [7:0]      reg_ptr,
    input  wire logic [7:0] rd_data
);

    chg_i2c_state_e state_r;
    logic       scl_q, sda_q, done_r, drive_r;
    logic [2:0] bitcnt_r;
    logic [7:0] shift_r, tx_r;
    logic       scl_rise, scl_fall, start_c, stop_c, ack_r;

    assign scl_rise = scl_i & ~scl_q;
    assign scl_fall = ~scl_i & scl_q;
    assign start_c  = scl_i & scl_q & sda_q & ~sda_i;
    assign stop_c   = scl_i & scl_q & ~sda_q & sda_i;
    // Open drain: only ever pulls low
    assign sda_o    = 1'b0;
    assign sda_oe_n = ~drive_r;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_r  <= S_IDLE;
            bitcnt_r <= 3'h0;
            done_r   <= 1'b0;
            drive_r  <= 1'b0;
            shift_r  <= 8'h00;
            tx_r     <= 8'h00;
            ack_r    <= 1'b0;
            map_ac   <= 1'b0;
            reg_ptr  <= 8'h00;
            wr_stb   <= 1'b0;
            wr_data  <= 8'h00;
        end else begin
            wr_stb <= 1'b0;
            if (start_c) begin
                state_r  <= S_ADDR;
                bitcnt_r <= 3'h0;
                done_r   <= 1'b0;
                drive_r  <= 1'b0;
            end else if (stop_c) begin
                state_r <= S_IDLE;
                drive_r <= 1'b0;
            end else begin
                if (scl_rise && (state_r == S_ADDR || state_r == S_PTR || state_r == S_WR || state_r == S_RD)) begin
                    shift_r  <= {shift_r[6:0], sda_i};
                    bitcnt_r <= bitcnt_r + 3'h1;
                    done_r   <= (bitcnt_r == 3'h7);
                end
                if (scl_rise && state_r == S_RD_ACK)
                    ack_r <= ~sda_i;
                if (scl_fall) begin
                    done_r <= 1'b0;
                    case (state_r)
                        S_ADDR: if (done_r) begin
                            if (shift_r[7:1] == I2C_ADDR_AC || shift_r[7:1] == I2C_ADDR_LIMIT) begin
                                map_ac  <= (shift_r[7:1] == I2C_ADDR_AC);
                                ack_r   <= shift_r[0];
                                drive_r <= 1'b1;
                                state_r <= S_ADDR_ACK;
                            end else begin
                                state_r <= S_IDLE;
                            end
                        end
                        S_ADDR_ACK: begin
                            if (ack_r) begin
                                drive_r <= ~rd_data[7];
                                tx_r    <= {rd_data[6:0], 1'b0};
                                state_r <= S_RD;
                            end else begin
                                drive_r <= 1'b0;
                                state_r <= S_PTR;
                            end
                        end
                        S_PTR: if (done_r) begin
                            reg_ptr <= shift_r;
                            drive_r <= 1'b1;
                            state_r <= S_PTR_ACK;
                        end
                        S_WR: if (done_r) begin
                            wr_stb  <= 1'b1;
                            wr_data <= shift_r;
                            drive_r <= 1'b1;
                            state_r <= S_WR_ACK;
                        end
                        S_PTR_ACK, S_WR_ACK: begin
                            if (state_r == S_WR_ACK)
                                reg_ptr <= reg_ptr + 8'h01;
                            drive_r <= 1'b0;
                            state_r <= S_WR;
                        end
                        S_RD: begin
                            if (done_r) begin
                                drive_r <= 1'b0;
                                reg_ptr <= reg_ptr + 8'h01;
                                state_r <= S_RD_ACK;
                            end else begin
                                drive_r <= ~tx_r[7];
                                tx_r    <= {tx_r[6:0], 1'b0};
                            end
                        end
                        S_RD_ACK: begin
                            if (ack_r) begin
                                drive_r <= ~rd_data[7];
                                tx_r    <= {rd_data[6:0], 1'b0};
                                state_r <= S_RD;
                            end else begin
                                state_r <= S_IDLE;
                            end
                        end
                        default: state_r <= S_IDLE;
                    endcase
                end
            end
        end
    end

endmodule // chg_i2c_target

// ---- hdl/chg_pkg.sv ----
// Contract
// - Safety limit resets 0x40, writable only before lock
// - Limit bits 7:4 cap charge current code
// - Limit bits 3:0 cap regulation voltage code
// - Other register write locks limits; clamp above
// - Limit resets on short battery or pin low
// - Indicator bits 7:6 select drive current
// - Indicator bit 4: charging-only or always lit
// - Indicator bits 3:2 select on-time
// - Indicator bits 1:0 select off-time
// - AC map answers at address 6AH
// - Writing bit 7 restarts timer, self-clearing
// - Reading bit 7 returns limit reset pin
// - Status bit 6 enables status pin, default 1
// - Status bits 5:4 report charge state
// - Status bits 2:0 report fault code
// - Control bits 7:6 select input current limit
// - Control bits 5:4 weak-battery threshold, default 3.7V
// - Control bit 3 termination enable, reset 0
// - Control bit 2 charger disable, reset 0
// - Control bit 1 high impedance, reset 0
// - Voltage bits 7:2 regulation code, default 3.54V
package chg_pkg;

    // Bus addresses (7-bit)
    localparam logic [6:0] I2C_ADDR_AC    = 7'h6a;
    localparam logic [6:0] I2C_ADDR_LIMIT = 7'h6b;

    // Register offsets
    localparam logic [7:0] OFS_STATUS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CONTROL     = 8'h01;
    localparam logic [7:0] OFS_VOLTAGE     = 8'h02;
    localparam logic [7:0] OFS_SAFETY      = 8'h06;
    localparam logic [7:0] OFS_INDICATOR   = 8'h07;

    // Reset values
    localparam logic       RST_STAT_EN   = 1'b1;
    localparam logic [7:0] RST_CONTROL   = 8'h70;
    localparam logic [7:0] RST_VOLTAGE   = 8'h0a;
    localparam logic [7:0] RST_SAFETY    = 8'h40;
    localparam logic [7:0] RST_INDICATOR = 8'h82;

    // Writable bits per register
    localparam logic [7:0] MASK_CONTROL   = 8'hfe;
    localparam logic [7:0] MASK_VOLTAGE   = 8'hfc;
    localparam logic [7:0] MASK_INDICATOR = 8'hdf;

    // Field positions
    localparam int BIT_TMR_RESTART = 7;
    localparam int BIT_STAT_EN     = 6;
    localparam int BIT_TE          = 3;
    localparam int BIT_CE          = 2;
    localparam int BIT_HZ          = 1;
    localparam int BIT_IND_BEHAV   = 4;

    // 4.2V limit offset above 3.5V, in 20mV steps
    localparam logic [5:0] VREG_LIMIT_BASE = 6'h23;
    localparam logic [1:0] CHG_STATE_CHARGING = 2'h1;
    localparam logic [1:0] IND_CUR_OFF        = 2'h0;
    localparam logic [1:0] IND_ON_CONSTANT    = 2'h3;

    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int MS_NS         = 1000000;
    localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
    localparam logic [11:0] IND_ON_MS_0  = 12'd130;
    localparam logic [11:0] IND_ON_MS_1  = 12'd260;
    localparam logic [11:0] IND_ON_MS_2  = 12'd520;
    localparam logic [11:0] IND_OFF_MS_0 = 12'd390;
    localparam logic [11:0] IND_OFF_MS_1 = 12'd780;
    localparam logic [11:0] IND_OFF_MS_2 = 12'd1560;
    localparam logic [11:0] IND_OFF_MS_3 = 12'd3120;

    typedef enum logic [8:0] {
        S_IDLE     = 9'h001,
        S_ADDR     = 9'h002,
        S_ADDR_ACK = 9'h004,
        S_PTR      = 9'h008,
        S_PTR_ACK  = 9'h010,
        S_WR       = 9'h020,
        S_WR_ACK   = 9'h040,
        S_RD       = 9'h080,
        S_RD_ACK   = 9'h100
    } chg_i2c_state_e;

endpackage

// ---- testbench/charger_config_register_bank_test.sv ----
`timescale 1ns/1ps
module charger_config_register_bank_test;
    import chg_pkg::*;
    localparam int MSP = 10;
    localparam logic [6:0] AC = I2C_ADDR_AC;
    localparam logic [6:0] LM = I2C_ADDR_LIMIT;
    logic mclk, rst, scl, host_pull, sda_line, sda_o, sda_oe_n, ok;
    logic [1:0] charge_state, input_current_limit_sel, weak_battery_threshold, indicator_current_sel;
    logic [2:0] fault_code;
    logic [3:0] fast_charge_req_code, fast_charge_code, max_charge_current_code, max_regulation_voltage_code;
    logic [5:0] battery_voltage_code;
    logic vbat_below_short, safety_limit_reset_pin_n, safety_timer_restart, stat_enable, termination_enable;
    logic charger_disable, high_impedance_select, safety_limit_locked, indicator_on;
    int failures, cmp_count, pulses, h, l;

    // Open drain, pulled up
    assign sda_line = ~host_pull & (sda_oe_n | sda_o);

    chg_config_regs #(.MS_CYCLES_P(MSP)) chg_config_regs_i (.scl_i(scl), .sda_i(sda_line), .*);
    chg_host_model chg_host_model_i (.mclk(mclk), .sda(sda_line), .scl(scl), .sda_pull(host_pull));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) if (safety_timer_restart === 1'b1) pulses++;

    task results;
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input string what, input logic [7:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task rchk(input logic [6:0] dev, input logic [7:0] ofs, exp, input string what);
        logic [7:0] d;
        logic a;
        chg_host_model_i.rd(dev, ofs, d, a);
        chk("rd ack", 8'h01, 8'(a));
        chk(what, exp, d);
    endtask
    task wreg(input logic [6:0] dev, input logic [7:0] ofs, data);
        logic a;
        chg_host_model_i.wr(dev, ofs, data, a);
        chk("wr ack", 8'h01, 8'(a));
    endtask
    task wait_lvl(input logic v, output int n);
        n = 0;
        while (indicator_on !== v) begin
            @(negedge mclk);
            n++;
            if (n > 40000) begin
                failures++;
                results;
            end
        end
    endtask

    initial begin
        rst = 1'b1;
        charge_state = 2'h0;
        fault_code = 3'h0;
        vbat_below_short = 1'b0;
        safety_limit_reset_pin_n = 1'b1;
        fast_charge_req_code = 4'hf;
        repeat (5) @(negedge mclk);
        rst = 1'b0;
        repeat (2) @(negedge mclk);
        rchk(AC, OFS_STATUS_CTRL, 8'hc0, "status");
        rchk(AC, OFS_CONTROL, 8'h70, "control");
        rchk(AC, OFS_VOLTAGE, 8'h08, "voltage");
        rchk(AC, 8'h05, 8'h00, "unmapped");
        rchk(LM, OFS_SAFETY, 8'h40, "limit");
        rchk(LM, OFS_INDICATOR, 8'h82, "indicator");
        chk("fast code", 8'h04, 8'(fast_charge_code));
        chg_host_model_i.wr(7'h55, OFS_CONTROL, 8'h00, ok);
        chk("foreign ack", 8'h00, 8'(ok));
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            charge_state = i[1:0];
            fault_code = i[2:0];
            safety_limit_reset_pin_n = i[0];
            rchk(AC, OFS_STATUS_CTRL, {i[0], 1'b1, i[1:0], 1'b0, i[2:0]}, "status");
        end
        $display("status test done");
        wreg(LM, OFS_SAFETY, 8'h11);
        wreg(LM, OFS_SAFETY, 8'h73);
        rchk(LM, OFS_SAFETY, 8'h73, "limit");
        wreg(AC, OFS_VOLTAGE, 8'hff);
        rchk(AC, OFS_VOLTAGE, 8'hfc, "voltage");
        chk("voltage code", 8'd38, 8'(battery_voltage_code));
        chk("fast code", 8'h07, 8'(fast_charge_code));
        wreg(LM, OFS_SAFETY, 8'h00);
        rchk(LM, OFS_SAFETY, 8'h73, "locked limit");
        for (int k = 0; k < 2; k++) begin
            vbat_below_short = k[0];
            safety_limit_reset_pin_n = k[0];
            repeat (5) @(negedge mclk);
            vbat_below_short = 1'b0;
            safety_limit_reset_pin_n = 1'b1;
            rchk(LM, OFS_SAFETY, 8'h40, "limit reset");
            wreg(AC, OFS_CONTROL, k[0] ? 8'h5b : 8'hff);
            wreg(LM, OFS_SAFETY, 8'hff);
            rchk(LM, OFS_SAFETY, 8'h40, "default limit");
            chk("control pins", k[0] ? 8'h5a : 8'hfe, {input_current_limit_sel, weak_battery_threshold,
                termination_enable, charger_disable, high_impedance_select, 1'b0});
            rchk(AC, OFS_CONTROL, k[0] ? 8'h5a : 8'hfe, "control");
        end
        chk("voltage code", 8'd35, 8'(battery_voltage_code));
        $display("limit test done");
        wreg(AC, OFS_STATUS_CTRL, 8'h80);
        chk("pulses", 8'h01, pulses[7:0]);
        rchk(AC, OFS_STATUS_CTRL, 8'hb7, "status");
        wreg(AC, OFS_STATUS_CTRL, 8'h40);
        chk("stat enable", 8'h01, 8'(stat_enable));
        chk("pulses", 8'h01, pulses[7:0]);
        $display("restart test done");
        wreg(LM, OFS_INDICATOR, 8'hff);
        rchk(LM, OFS_INDICATOR, 8'hdf, "indicator");
        repeat (50) @(negedge mclk);
        chk("steady on", 8'h01, 8'(indicator_on));
        chk("drive", 8'h03, 8'(indicator_current_sel));
        wreg(LM, OFS_INDICATOR, 8'h3f);
        chk("drive off", 8'h00, 8'(indicator_on));
        wreg(LM, OFS_INDICATOR, 8'h8c);
        repeat (50) @(negedge mclk);
        chk("not charging", 8'h00, 8'(indicator_on));
        charge_state = CHG_STATE_CHARGING;
        repeat (50) @(negedge mclk);
        chk("charging", 8'h01, 8'(indicator_on));
        for (int i = 0; i < 2; i++) begin
            wreg(LM, OFS_INDICATOR, {4'h5, i[1:0], i[1:0]});
            wait_lvl(1'b0, h);
            wait_lvl(1'b1, h);
            wait_lvl(1'b0, h);
            wait_lvl(1'b1, l);
            chk("on time", 8'h01, 8'((h - ((130*MSP) << i)) inside {[-2*MSP:2*MSP]}));
            chk("off time", 8'h01, 8'((l - ((390*MSP) << i)) inside {[-2*MSP:2*MSP]}));
        end
        $display("indicator test done");
        results;
    end
endmodule // charger_config_register_bank_test

// ---- testbench/chg_cfg_asserts.sv ----
`timescale 1ns/1ps
module chg_cfg_asserts
    import chg_pkg::*;
(
    // Clock and reset
    input wire logic       mclk,
    input wire logic       rst,
    // Limit reset sources
    input wire logic       vbat_below_short,
    input wire logic       safety_limit_reset_pin_n,
    // Controls
    input wire logic       safety_timer_restart,
    input wire logic       stat_enable,
    input wire logic [1:0] input_current_limit_sel,
    input wire logic [1:0] weak_battery_threshold,
    input wire logic       termination_enable,
    input wire logic       charger_disable,
    input wire logic       high_impedance_select,
    input wire logic [5:0] battery_voltage_code,
    input wire logic [3:0] fast_charge_code,
    // Limits and indicator
    input wire logic [3:0] max_charge_current_code,
    input wire logic [3:0] max_regulation_voltage_code,
    input wire logic       safety_limit_locked,
    input wire logic [1:0] indicator_current_sel,
    input wire logic       indicator_on
);
    default clocking dcb @(posedge mclk);
    endclocking
    default disable iff (rst);

    restart_pulse_a: assert property (safety_timer_restart |=> !safety_timer_restart)
        else $error("restart wide");
    lock_hold_a: assert property ((safety_limit_locked && !vbat_below_short && safety_limit_reset_pin_n)[*4]
        |=> safety_limit_locked) else $error("lock dropped");
    limits_frozen_a: assert property ((safety_limit_locked && !vbat_below_short && safety_limit_reset_pin_n)
        |=> $stable(max_charge_current_code) && $stable(max_regulation_voltage_code))
        else $error("limits moved");
    limit_reset_a: assert property ((vbat_below_short || !safety_limit_reset_pin_n) |-> ##[1:3]
        (max_charge_current_code == 4'h4 && max_regulation_voltage_code == 4'h0 && !safety_limit_locked))
        else $error("no limit reset");
    volt_clamp_a: assert property ($stable(max_regulation_voltage_code)[*3] |->
        {1'b0, battery_voltage_code} <= {3'h0, max_regulation_voltage_code} + {1'b0, VREG_LIMIT_BASE})
        else $error("volt over cap");
    curr_clamp_a: assert property ($stable(max_charge_current_code)[*3] |->
        fast_charge_code <= max_charge_current_code) else $error("curr over cap");
    ind_off_a: assert property ((indicator_current_sel == IND_CUR_OFF)[*3] |-> !indicator_on)
        else $error("lit when off");
    reset_values_a: assert property ($fell(rst) |-> stat_enable && input_current_limit_sel == 2'h1
        && weak_battery_threshold == 2'h3 && !termination_enable && !charger_disable && !high_impedance_select
        && battery_voltage_code == 6'h02 && max_charge_current_code == 4'h4 && indicator_current_sel == 2'h2)
        else $error("bad reset");

    cover property (safety_timer_restart);
    cover property ($rose(safety_limit_locked));
    cover property (indicator_on ##1 !indicator_on);
endmodule // chg_cfg_asserts

bind chg_config_regs chg_cfg_asserts chg_cfg_asserts_i (.*);

// ---- testbench/chg_host_model.sv ----
`timescale 1ns/1ps
module chg_host_model (
    // Clock and bus pins
    input  wire logic mclk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_pull
);
    initial {scl, sda_pull} = 2'b10;
    // Four mclk per phase
    task phase;
        repeat (4) @(negedge mclk);
    endtask
    task start;
        sda_pull = 1'b0;
        phase;
        scl = 1'b1;
        phase;
        sda_pull = 1'b1;
        phase;
        scl = 1'b0;
        phase;
    endtask
    task stop;
        sda_pull = 1'b1;
        phase;
        scl = 1'b1;
        phase;
        sda_pull = 1'b0;
        phase;
    endtask
    // Nine bits; 1 releases the line
    task xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            sda_pull = ~tx[i];
            phase;
            scl = 1'b1;
            phase;
            rx[i] = sda;
            scl = 1'b0;
            phase;
        end
    endtask
    task wr(input logic [6:0] dev, input logic [7:0] ofs, data, output logic ok);
        logic [8:0] r0, r1, r2;
        start;
        xfer({dev, 1'b0, 1'b1}, r0);
        xfer({ofs, 1'b1}, r1);
        xfer({data, 1'b1}, r2);
        stop;
        ok = ~r0[0] & ~r1[0] & ~r2[0];
    endtask
    task rd(input logic [6:0] dev, input logic [7:0] ofs, output logic [7:0] data, output logic ok);
        logic [8:0] r0, r1, r2, r3;
        start;
        xfer({dev, 1'b0, 1'b1}, r0);
        xfer({ofs, 1'b1}, r1);
        start;
        xfer({dev, 1'b1, 1'b1}, r2);
        xfer(9'h1ff, r3);
        stop;
        data = r3[8:1];
        ok = ~r0[0] & ~r1[0] & ~r2[0];
    endtask
endmodule // chg_host_model
